// ==== core/tms_top.sv ====
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tms_consts.svh"
module tms_top import tms_pkg::*; #(
	parameter int LEVEL_W = 8,
	parameter int TICK_CYCLES = `TMS_TICK_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic test_enable_in,
	input wire logic test_select_first_in,
	input wire logic test_select_second_in,
	input wire logic bandwidth_select_in,
	input wire logic tracking_inhibit_in,
	input wire logic [1:0] acq_mode_in,
	input wire logic symbol_tick_in,
	input wire logic filter_level_in,
	input wire logic peak_comp_in,
	input wire logic valley_comp_in,
	input wire logic [1:0] adc_code_in,
	input wire logic [3:0] bus_addr_in,
	input wire logic [31:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic aux_output_zero_out,
	output logic aux_output_one_out,
	output logic wide_band_out,
	output logic converter_enable_out,
	output logic [1:0] adc_code_out,
	output logic [LEVEL_W-1:0] peak_level_out,
	output logic [LEVEL_W-1:0] valley_level_out,
	output logic data_valid_out,
	output logic [31:0] bus_rdata_out
);
	typedef struct packed {
		tms_test_e test;
		logic aux0;
		logic aux1;
		logic wide;
		logic conv_en;
		logic [1:0] adc;
		logic [2:0] fast_need;
		logic [2:0] slow_need;
		logic [9:0] tick_cnt;
		logic [31:0] rdata;
	} tms_top_s;

	if (LEVEL_W < 4 || LEVEL_W > 24) begin : g_chk_w
		$error("tms_top level width out of range");
	end
	if (TICK_CYCLES < 1 || TICK_CYCLES > 1024) begin : g_chk_t
		$error("tms_top tick divider out of range");
	end

	tms_top_s r;
	tms_top_s next_r;
	tms_test_e cur;
	tms_acq_e acq;
	logic tracking;
	logic peak_run;
	logic valley_run;
	logic tick;

	tms_ctr_if #(.W(LEVEL_W)) peak_link();
	tms_ctr_if #(.W(LEVEL_W)) valley_link();
	tms_warm_if warm_link();

	function automatic tms_test_e decode(input logic te, input logic s1, input logic s2);
		tms_test_e m;
		m = TM_NORMAL;
		if (te) begin
			case ({s1, s2})
				2'b00: m = TM_RESERVED;
				2'b01: m = TM_FILTER;
				2'b10: m = TM_COMP;
				2'b11: m = TM_THRESH;
				default: m = TM_RESERVED;
			endcase
		end
		return m;
	endfunction : decode

	// selection decoded from the live pins every cycle
	assign cur = decode(test_enable_in, test_select_first_in, test_select_second_in);
	assign acq = tms_acq_e'(acq_mode_in);
	assign tracking = (acq == ACQ_SLOW) || (acq == ACQ_FAST);
	assign tick = (r.tick_cnt == 10'h000);

	// counter gating per mode
	always_comb begin
		peak_run = 1'b0;
		valley_run = 1'b0;
		case (cur)
			TM_NORMAL, TM_RESERVED: begin
				peak_run = tracking && !tracking_inhibit_in;
				valley_run = tracking && !tracking_inhibit_in;
			end
			TM_FILTER: begin
				peak_run = 1'b0;
				valley_run = 1'b0;
			end
			TM_COMP: begin
				peak_run = 1'b0;
				valley_run = 1'b0;
			end
			TM_THRESH: begin
				peak_run = tracking && !bandwidth_select_in;
				valley_run = tracking && !tracking_inhibit_in;
			end
			default: begin
				peak_run = 1'b0;
				valley_run = 1'b0;
			end
		endcase
	end

	assign peak_link.run = peak_run;
	assign peak_link.fast = (acq == ACQ_FAST);
	assign peak_link.step = tick;
	assign peak_link.attack = peak_comp_in;
	assign peak_link.decay = !peak_comp_in;
	assign valley_link.run = valley_run;
	assign valley_link.fast = (acq == ACQ_FAST);
	assign valley_link.step = tick;
	assign valley_link.attack = valley_comp_in;
	assign valley_link.decay = !valley_comp_in;

	tms_dac_counter #(.W(LEVEL_W), .UP_ON_ATTACK(1'b1)) u_peak (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.link(peak_link.ctr)
	);
	tms_dac_counter #(.W(LEVEL_W), .UP_ON_ATTACK(1'b0)) u_valley (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.link(valley_link.ctr)
	);

	assign warm_link.tick = symbol_tick_in;
	assign warm_link.acq = acq;
	assign warm_link.fast_need = r.fast_need;
	assign warm_link.slow_need = r.slow_need;

	tms_warmup u_warm (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.w(warm_link.mon)
	);

	// routing, filter corner, converter and register port
	always_comb begin
		next_r = r;
		next_r.test = cur;
		next_r.tick_cnt = tick ? 10'(TICK_CYCLES - 1) : r.tick_cnt - 10'h001;
		next_r.wide = bandwidth_select_in;
		next_r.conv_en = 1'b1;
		next_r.aux0 = 1'b0;
		next_r.aux1 = 1'b0;
		case (cur)
			TM_FILTER: begin
				next_r.aux1 = filter_level_in;
				next_r.conv_en = 1'b0;
			end
			TM_COMP: begin
				next_r.aux0 = peak_comp_in;
				next_r.aux1 = valley_comp_in;
			end
			TM_THRESH: begin
				next_r.aux0 = adc_code_in[0];
				next_r.aux1 = adc_code_in[1];
				next_r.wide = 1'b0;
			end
			default: begin
				next_r.aux0 = 1'b0;
			end
		endcase
		if (next_r.conv_en) begin
			next_r.adc = adc_code_in;
		end
		if (bus_wr_in && bus_addr_in == `TMS_OFF_CTRL) begin
			next_r.fast_need = bus_wdata_in[`TMS_CTRL_FAST_POS +: 3];
			next_r.slow_need = bus_wdata_in[`TMS_CTRL_SLOW_POS +: 3];
		end
		next_r.rdata = 32'h0000_0000;
		if (bus_rd_in) begin
			case (bus_addr_in)
				`TMS_OFF_CTRL: begin
					next_r.rdata[`TMS_CTRL_FAST_POS +: 3] = r.fast_need;
					next_r.rdata[`TMS_CTRL_SLOW_POS +: 3] = r.slow_need;
				end
				`TMS_OFF_STATUS: begin
					next_r.rdata[4:0] = r.test;
					next_r.rdata[`TMS_STAT_VALID_POS] = warm_link.valid;
					next_r.rdata[`TMS_STAT_FROZEN_POS] = !peak_run && !valley_run;
				end
				`TMS_OFF_PEAK: next_r.rdata[LEVEL_W-1:0] = peak_link.level;
				`TMS_OFF_VALLEY: next_r.rdata[LEVEL_W-1:0] = valley_link.level;
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '{test: TM_NORMAL, aux0: 1'b0, aux1: 1'b0, wide: 1'b0, conv_en: 1'b1,
				adc: 2'h0, fast_need: `TMS_FAST_NEED_RST, slow_need: `TMS_SLOW_NEED_RST,
				tick_cnt: 10'h000, rdata: 32'h0000_0000};
		end else begin
			r <= next_r;
		end
	end

	assign aux_output_zero_out = r.aux0;
	assign aux_output_one_out = r.aux1;
	assign wide_band_out = r.wide;
	assign converter_enable_out = r.conv_en;
	assign adc_code_out = r.adc;
	assign peak_level_out = peak_link.level;
	assign valley_level_out = valley_link.level;
	assign data_valid_out = warm_link.valid;
	assign bus_rdata_out = r.rdata;

	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	logic in_filter;
	logic in_comp;
	logic in_thresh;
	assign in_filter = test_enable_in && !test_select_first_in && test_select_second_in;
	assign in_comp = test_enable_in && test_select_first_in && !test_select_second_in;
	assign in_thresh = test_enable_in && test_select_first_in && test_select_second_in;

	property p_filter_route;
		in_filter |=> aux_output_one_out == $past(filter_level_in) && !aux_output_zero_out;
	endproperty
	a_filter_route: assert property (p_filter_route) else $error("filter not on aux one");

	property p_filter_corner;
		in_filter |=> wide_band_out == $past(bandwidth_select_in);
	endproperty
	a_filter_corner: assert property (p_filter_corner) else $error("filter corner wrong");

	property p_filter_freeze;
		in_filter ##1 in_filter |=> $stable(peak_level_out) && $stable(valley_level_out)
			&& $stable(adc_code_out) && !converter_enable_out;
	endproperty
	a_filter_freeze: assert property (p_filter_freeze) else $error("filter test moved state");

	property p_comp_enter;
		in_comp |=> r.test == TM_COMP && converter_enable_out;
	endproperty
	a_comp_enter: assert property (p_comp_enter) else $error("comparator mode not entered");

	property p_comp_route;
		in_comp |=> aux_output_zero_out == $past(peak_comp_in)
			&& aux_output_one_out == $past(valley_comp_in);
	endproperty
	a_comp_route: assert property (p_comp_route) else $error("comparators misrouted");

	property p_comp_hold;
		in_comp [*2] |=> $stable(peak_level_out) && $stable(valley_level_out);
	endproperty
	a_comp_hold: assert property (p_comp_hold) else $error("levels moved in comparator mode");

	property p_hold_block;
		(!test_enable_in && acq_mode_in == ACQ_HOLD && tick) |=> $stable(peak_level_out)
			&& $stable(valley_level_out);
	endproperty
	a_hold_block: assert property (p_hold_block) else $error("hold let a level move");

	property p_thresh_route;
		in_thresh |=> {aux_output_one_out, aux_output_zero_out} == $past(adc_code_in);
	endproperty
	a_thresh_route: assert property (p_thresh_route) else $error("converter bits misrouted");

	property p_thresh_peak_gate;
		in_thresh && bandwidth_select_in |=> $stable(peak_level_out);
	endproperty
	a_thresh_peak_gate: assert property (p_thresh_peak_gate) else $error("peak not gated");

	property p_thresh_valley_gate;
		in_thresh && tracking_inhibit_in |=> $stable(valley_level_out);
	endproperty
	a_thresh_valley_gate: assert property (p_thresh_valley_gate) else $error("valley not gated");

	property p_thresh_narrow;
		in_thresh |=> !wide_band_out;
	endproperty
	a_thresh_narrow: assert property (p_thresh_narrow) else $error("threshold corner not 1 kHz");

	property p_retarget;
		test_enable_in && $past(test_enable_in)
			&& $changed({test_select_first_in, test_select_second_in}) |=> r.test != $past(r.test);
	endproperty
	a_retarget: assert property (p_retarget) else $error("selection change ignored");

	property p_peak_moves;
		in_thresh && !bandwidth_select_in && acq_mode_in == ACQ_SLOW && tick
			&& peak_comp_in && peak_level_out < 8'hF0 |=> peak_level_out == $past(peak_level_out) + 1;
	endproperty
	a_peak_moves: assert property (p_peak_moves) else $error("peak counter stuck in threshold");

	c_filter: cover property (in_filter ##1 in_filter);
	c_comp: cover property (in_comp [*3]);
	c_thresh_step: cover property (in_thresh && tick && acq_mode_in == ACQ_SLOW);
	c_valid: cover property ($rose(data_valid_out));
endmodule : tms_top

// ==== inc/tms_consts.svh ====
// Summary of operation
// - enable high, first select low, second high: filter test, filter on aux one
// - filter test: bandwidth select low gives 1 kHz, high gives 2 kHz
// - filter test: level counters and 2-bit converter frozen, decay counters held at 1
// - enable high, first select high, second low: comparator access test
// - comparator access: peak comparator on aux zero, valley on aux one
// - comparator access: both level counters held constant by hold behaviour
// - hold blocks every counter update, attack or decay, levels unchanged
// - enable and both selects high: threshold test, converter bits on aux pins
// - threshold test: bandwidth select high stops the peak counter
// - threshold test: tracking inhibit high stops the valley counter
// - threshold test: filter forced to the 1 kHz corner
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH
`define TMS_OFF_CTRL 4'h0
`define TMS_OFF_STATUS 4'h4
`define TMS_OFF_PEAK 4'h8
`define TMS_OFF_VALLEY 4'hC
`define TMS_CTRL_FAST_POS 0
`define TMS_CTRL_SLOW_POS 4
`define TMS_STAT_VALID_POS 5
`define TMS_STAT_FROZEN_POS 6
`define TMS_FAST_NEED_RST 3'h1
`define TMS_SLOW_NEED_RST 3'h5
`define TMS_LEVEL_RST 8'h80
`define TMS_CLK_NS 40
`define TMS_TICK_NS 26042
`define TMS_TICK_CYCLES (`TMS_TICK_NS / `TMS_CLK_NS)
`define TMS_DECAY_DIV 6'h28
`define TMS_FAST_ATTACK 4
`define TMS_FAST_DECAY 8
`endif

// ==== inc/tms_pkg.sv ====
package tms_pkg;
	typedef enum logic [4:0] {
		TM_NORMAL = 5'h01,
		TM_RESERVED = 5'h02,
		TM_FILTER = 5'h04,
		TM_COMP = 5'h08,
		TM_THRESH = 5'h10
	} tms_test_e;
	typedef enum logic [1:0] {
		ACQ_OFF = 2'h0,
		ACQ_HOLD = 2'h1,
		ACQ_SLOW = 2'h2,
		ACQ_FAST = 2'h3
	} tms_acq_e;
	typedef enum logic [3:0] {
		W_COLD = 4'h1,
		W_FAST = 4'h2,
		W_SLOW = 4'h4,
		W_READY = 4'h8
	} tms_warm_e;
endpackage : tms_pkg

// ==== inc/tms_links.sv ====
`timescale 1ns/1ps
interface tms_ctr_if #(parameter int W = 8);
	logic run;
	logic fast;
	logic step;
	logic attack;
	logic decay;
	logic [W-1:0] level;
	modport ctl(output run, fast, step, attack, decay, input level);
	modport ctr(input run, fast, step, attack, decay, output level);
endinterface : tms_ctr_if

interface tms_warm_if;
	import tms_pkg::*;
	logic tick;
	tms_acq_e acq;
	logic [2:0] fast_need;
	logic [2:0] slow_need;
	logic valid;
	modport ctl(output tick, acq, fast_need, slow_need, input valid);
	modport mon(input tick, acq, fast_need, slow_need, output valid);
endinterface : tms_warm_if

// ==== core/tms_dac_counter.sv ====
`timescale 1ns/1ps
`include "tms_consts.svh"
module tms_dac_counter import tms_pkg::*; #(
	parameter int W = 8,
	parameter bit UP_ON_ATTACK = 1'b1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	tms_ctr_if.ctr link
);
	typedef struct packed {
		logic [W-1:0] level;
		logic [5:0] div;
	} tms_ctr_s;
	localparam logic [W-1:0] MAX = {W{1'b1}};
	tms_ctr_s r;
	tms_ctr_s next_r;
	logic [W-1:0] amt;
	if (W < 4) begin : g_chk
		$error("tms_dac_counter needs at least 4 bits");
	end
	always_comb begin
		next_r = r;
		amt = link.attack ? (link.fast ? W'(`TMS_FAST_ATTACK) : W'(1)) :
			(link.fast ? W'(`TMS_FAST_DECAY) : W'(1));
		if (!link.run) begin
			next_r.div = 6'h01;
		end else if (link.step) begin
			if (link.attack || (link.decay && (link.fast || r.div == 6'h01))) begin
				if (link.attack == UP_ON_ATTACK) begin
					next_r.level = (r.level > MAX - amt) ? MAX : r.level + amt;
				end else begin
					next_r.level = (r.level < amt) ? '0 : r.level - amt;
				end
			end
			if (link.attack || link.fast) begin
				next_r.div = 6'h01;
			end else if (link.decay) begin
				next_r.div = (r.div == 6'h01) ? `TMS_DECAY_DIV : r.div - 6'h01;
			end
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '{level: W'(`TMS_LEVEL_RST), div: 6'h01};
		end else begin
			r <= next_r;
		end
	end
	assign link.level = r.level;
endmodule : tms_dac_counter

// ==== core/tms_warmup.sv ====
`timescale 1ns/1ps
module tms_warmup import tms_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	tms_warm_if.mon w
);
	typedef struct packed {
		tms_warm_e st;
		logic [2:0] cnt;
		logic valid;
	} tms_wu_s;
	tms_wu_s r;
	tms_wu_s next_r;
	always_comb begin
		next_r = r;
		if (w.acq == ACQ_OFF) begin
			next_r.st = W_COLD;
			next_r.cnt = 3'h0;
		end else if (w.tick) begin
			case (r.st)
				W_COLD, W_READY: begin
					if (w.acq == ACQ_FAST) begin
						next_r.st = W_FAST;
						next_r.cnt = 3'h1;
					end
				end
				W_FAST: begin
					if (w.acq == ACQ_FAST) begin
						next_r.cnt = (r.cnt == 3'h7) ? r.cnt : r.cnt + 3'h1;
					end else if (w.acq == ACQ_SLOW && r.cnt >= w.fast_need) begin
						next_r.st = (w.slow_need <= 3'h1) ? W_READY : W_SLOW;
						next_r.cnt = 3'h1;
					end
				end
				W_SLOW: begin
					if (w.acq == ACQ_FAST) begin
						next_r.st = W_FAST;
						next_r.cnt = 3'h1;
					end else if (w.acq == ACQ_SLOW) begin
						next_r.cnt = r.cnt + 3'h1;
						if (r.cnt + 3'h1 >= w.slow_need) begin
							next_r.st = W_READY;
						end
					end
				end
				default: next_r.st = W_COLD;
			endcase
		end
		next_r.valid = (next_r.st == W_READY);
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '{st: W_COLD, cnt: 3'h0, valid: 1'b0};
		end else begin
			r <= next_r;
		end
	end
	assign w.valid = r.valid;
endmodule : tms_warmup

// ==== test/tms_decoder_model.sv ====
`timescale 1ns/1ps
module tms_decoder_model #(
	parameter int SYM = 20
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic test_req_in,
	input wire logic data_phase_in,
	output logic test_enable_out,
	output logic [1:0] acq_mode_out,
	output logic symbol_tick_out
);
	int cnt;
	int syms;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 0;
			syms <= 0;
			test_enable_out <= 1'b0;
			acq_mode_out <= 2'h3;
			symbol_tick_out <= 1'b0;
		end else begin
			test_enable_out <= test_req_in;
			symbol_tick_out <= (cnt == SYM - 1);
			cnt <= (cnt == SYM - 1) ? 0 : cnt + 1;
			if (symbol_tick_out) begin
				syms <= syms + 1;
			end
			if (syms < 1) begin
				acq_mode_out <= 2'h3;
			end else if (syms < 6 || !data_phase_in) begin
				acq_mode_out <= 2'h2;
			end else begin
				acq_mode_out <= 2'h1;
			end
		end
	end
endmodule : tms_decoder_model

// ==== test/test_mode_select_and_warmup_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); \
	end \
end
module test_mode_select_and_warmup_test;
	import tms_pkg::*;
	localparam int SYM = 20;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic test_req, data_phase, test_enable, s1, s2, bw, ti, tick, filt, pc, vc;
	logic [1:0] acq, adc_in, adc_out;
	logic [1:0] last_adc = 2'h0;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, d;
	logic wr, rd, aux0, aux1, wide, conv_en, valid;
	logic [7:0] peak, valley;
	logic [7:0] cases [7] = '{8'h03, 8'hA0, 8'hC0, 8'hE3, 8'hF1, 8'hEA, 8'h04};
	int n_errors = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h556F;

	initial begin
		forever #20 clk_in = ~clk_in;
	end

	tms_top #(.TICK_CYCLES(4)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.test_enable_in(test_enable), .test_select_first_in(s1), .test_select_second_in(s2),
		.bandwidth_select_in(bw), .tracking_inhibit_in(ti), .acq_mode_in(acq),
		.symbol_tick_in(tick), .filter_level_in(filt), .peak_comp_in(pc), .valley_comp_in(vc),
		.adc_code_in(adc_in), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr),
		.bus_rd_in(rd), .aux_output_zero_out(aux0), .aux_output_one_out(aux1),
		.wide_band_out(wide), .converter_enable_out(conv_en), .adc_code_out(adc_out),
		.peak_level_out(peak), .valley_level_out(valley), .data_valid_out(valid),
		.bus_rdata_out(rdata));

	tms_decoder_model #(.SYM(SYM)) partner (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.test_req_in(test_req), .data_phase_in(data_phase), .test_enable_out(test_enable),
		.acq_mode_out(acq), .symbol_tick_out(tick));

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task results();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	task bus_read(input logic [3:0] a, output logic [31:0] q);
		@(posedge clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		q = rdata;
	endtask : bus_read

	task bus_write(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : bus_write

	task route(input logic [1:0] sel);
		logic [31:0] r;
		logic [31:0] st;
		r = rnd();
		@(posedge clk_in);
		test_req <= 1'b1;
		s1 <= sel[1];
		s2 <= sel[0];
		bw <= r[0];
		filt <= r[1];
		pc <= r[2];
		vc <= r[3];
		adc_in <= r[5:4];
		repeat (3) @(posedge clk_in);
		#1;
		if (sel != 2'b01) begin
			last_adc = r[5:4];
		end
		`CHK(adc_out, last_adc)
		case (sel)
			2'b00: `CHK({aux1, aux0}, 2'b00)
			2'b01: begin
				`CHK(aux1, r[1])
				`CHK(wide, r[0])
				`CHK(conv_en, 1'b0)
			end
			2'b10: begin
				`CHK(aux0, r[2])
				`CHK(aux1, r[3])
				`CHK(conv_en, 1'b1)
			end
			default: begin
				`CHK(aux0, r[4])
				`CHK(aux1, r[5])
				`CHK(wide, 1'b0)
			end
		endcase
		bus_read(4'h4, st);
		`CHK(st[4:0], 5'h02 << sel)
		$display("route %0d done", sel);
	endtask : route

	task gate(input logic [7:0] c);
		logic [7:0] p0;
		logic [7:0] v0;
		@(posedge clk_in);
		test_req <= c[7];
		s1 <= c[6];
		s2 <= c[5];
		bw <= c[4];
		ti <= c[3];
		data_phase <= c[2];
		pc <= 1'b1;
		vc <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		p0 = peak;
		v0 = valley;
		repeat (24) @(posedge clk_in);
		#1;
		`CHK(peak - p0, c[1] ? 8'h06 : 8'h00)
		`CHK(v0 - valley, c[0] ? 8'h06 : 8'h00)
		bus_read(4'h4, p0);
		`CHK(p0[6], c[1:0] == 2'b00)
		$display("gate %0h done", c);
	endtask : gate

	initial begin
		#(100000 * 40);
		n_errors++;
		results();
	end

	initial begin
		{test_req, data_phase, bw, ti, filt, wr, rd, s1, s2} = '0;
		{pc, vc} = 2'b11;
		adc_in = 2'h0;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (6) @(posedge clk_in);
		#1;
		`CHK({aux1, aux0, wide, conv_en, valid}, 5'b00010)
		`CHK({peak, valley}, 16'h8080)
		rst_n_in = 1'b1;
		repeat (5 * SYM + SYM / 2) @(posedge clk_in);
		#1;
		`CHK(valid, 1'b0)
		for (int k = 0; k < 2 * SYM && valid !== 1'b1; k++) begin
			@(posedge clk_in);
			#1;
		end
		`CHK(valid, 1'b1)
		if (valid !== 1'b1) begin
			results();
		end
		bus_read(4'h4, d);
		`CHK(d[5], 1'b1)
		$display("warm-up done");
		bus_read(4'h0, d);
		`CHK(d[6:0], 7'h51)
		bus_read(4'h2, d);
		`CHK(d, 32'h0)
		bus_write(4'h0, 32'h32);
		bus_read(4'h0, d);
		`CHK(d[6:0], 7'h32)
		bus_write(4'h0, 32'h51);
		$display("register bus done");
		for (int i = 0; i < 8; i++) begin
			route(i[1:0]);
		end
		foreach (cases[j]) begin
			gate(cases[j]);
		end
		results();
	end
endmodule : test_mode_select_and_warmup_test
